// [sbp_params.svh]
`ifndef SBP_PARAMS_SVH
`define SBP_PARAMS_SVH

// ****************************************************
// Register indices (byte address is four times index)
// ****************************************************
`define SBP_ADDR_W 8
`define SBP_IDX_MAIN_CONTROL 3'h0
`define SBP_IDX_BUFFER_AND_PHASE 3'h1
`define SBP_IDX_IRQ_ENABLES 3'h2
`define SBP_IDX_IRQ_FLAGS 3'h3
`define SBP_IDX_DATA_PORT 3'h4

// ****************************************************
// Reset values and writable masks
// ****************************************************
`define SBP_RST_REG 8'h00
`define SBP_MASK_MAIN 8'h77
`define SBP_MASK_BUF 8'hC7
`define SBP_MASK_IEN 8'hF1
`define SBP_MASK_W1C 8'hD1

// ****************************************************
// Field positions
// ****************************************************
`define SBP_BIT_ENABLE 0
`define SBP_BIT_MASTER 5
`define SBP_BIT_LSB_FIRST 6
`define SBP_BIT_BUFFER_MODE_ON 7
`define SBP_BIT_BUFFER_WAIT_RECEIVE 6
`define SBP_BIT_MODE_PHASE 0
`define SBP_BIT_MODE_POLARITY 1
`define SBP_BIT_RX_COMPLETE_FLAG 7
`define SBP_BIT_TX_COMPLETE_FLAG 6
`define SBP_BIT_TX_BUFFER_EMPTY_FLAG 5
`define SBP_BIT_SELECT_TRIGGER_FLAG 4
`define SBP_BIT_BUF_OVERFLOW_FLAG 0
`define SBP_BIT_PLAIN_IRQ_ENABLE 0

// ****************************************************
// Counts
// ****************************************************
`define SBP_LAST_BIT 3'h7
`define SBP_RX_DEPTH 2'h2

`endif

// [sbp_pkg.sv]
`include "sbp_params.svh"

package sbp_pkg;

  typedef enum logic [0:0] {
    SBP_IDLE  = 1'b0,
    SBP_SHIFT = 1'b1
  } sbp_xfer_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`SBP_ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } sbp_apb_req_t;

  typedef struct packed {
    logic sck1;
    logic sck2;
    logic sck3;
    logic sel1;
    logic sel2;
    logic sel3;
    logic mosi1;
    logic mosi2;
  } sbp_sync_t;

  typedef struct packed {
    sbp_sync_t sy;
    sbp_xfer_t xfer;
    logic [7:0] main_ctl;
    logic [7:0] buf_ctl;
    logic [7:0] ien;
    logic [7:0] flags;
    logic [7:0] sh;
    logic [7:0] txbuf;
    logic tx_full;
    logic sh_full;
    logic [2:0] bitcnt;
    logic [1:0][7:0] rxf;
    logic [1:0] rx_cnt;
    logic ev1;
    logic txc1;
    logic ev2;
    logic pready;
    logic pslverr;
    logic [7:0] rdata;
    logic irq;
    logic miso;
    logic miso_oe;
  } sbp_state_t;

endpackage

// [sbp_spi_slave.sv]
// Local design decision: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module sbp_spi_slave (
  input wire logic clock,
  input wire logic rst_n,
  input wire sbp_pkg::sbp_apb_req_t apb_req,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sck,
  input wire logic mosi,
  input wire logic ss_n,
  input wire logic miso_dir_out,
  input wire logic sleep_deep,
  output logic miso_o,
  output logic miso_oe,
  output logic irq
);

  // ****************************************************
  // State
  // ****************************************************
  sbp_pkg::sbp_state_t q;
  sbp_pkg::sbp_state_t d;

  assign prdata = {24'h00_0000, q.rdata};
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign miso_o = q.miso;
  assign miso_oe = q.miso_oe;
  assign irq = q.irq;

  // ****************************************************
  // Configuration decode
  // ****************************************************
  logic enabled;
  logic master;
  logic lsb_first;
  logic buf_mode;
  logic wait_rx;
  logic cpha;
  logic cpol;
  logic selected;

  assign enabled = q.main_ctl[`SBP_BIT_ENABLE];
  assign master = q.main_ctl[`SBP_BIT_MASTER];
  assign lsb_first = q.main_ctl[`SBP_BIT_LSB_FIRST];
  assign buf_mode = q.buf_ctl[`SBP_BIT_BUFFER_MODE_ON];
  assign wait_rx = q.buf_ctl[`SBP_BIT_BUFFER_WAIT_RECEIVE];
  assign cpha = q.buf_ctl[`SBP_BIT_MODE_PHASE];
  assign cpol = q.buf_ctl[`SBP_BIT_MODE_POLARITY];
  // Deep sleep looks like a deselect so a transfer is cut short
  assign selected = enabled & ~master & ~q.sy.sel2 & ~sleep_deep;

  // ****************************************************
  // Clock edges
  // ****************************************************
  logic sck_rise;
  logic sck_fall;
  logic lead_edge;
  logic trail_edge;
  logic sample_edge;
  logic setup_edge;
  logic select_fell;

  // Edge finders read the second and third stages only
  assign sck_rise = q.sy.sck2 & ~q.sy.sck3;
  assign sck_fall = ~q.sy.sck2 & q.sy.sck3;
  assign lead_edge = cpol ? sck_fall : sck_rise;
  assign trail_edge = cpol ? sck_rise : sck_fall;
  assign sample_edge = cpha ? trail_edge : lead_edge;
  assign setup_edge = cpha ? lead_edge : trail_edge;
  assign select_fell = q.sy.sel3 & ~q.sy.sel2;

  // ****************************************************
  // Bus decode
  // ****************************************************
  logic bus_acc;
  logic bus_done;
  logic addr_hit;
  logic [2:0] idx;
  logic wr_data;
  logic rd_data;
  logic [7:0] wbyte;

  assign bus_acc = apb_req.psel & apb_req.penable;
  assign bus_done = bus_acc & q.pready;
  assign idx = apb_req.paddr[4:2];
  assign addr_hit = (apb_req.paddr[1:0] == 2'h0) &
                    (apb_req.paddr[`SBP_ADDR_W-1:5] == '0) &
                    (idx <= `SBP_IDX_DATA_PORT);
  assign wbyte = apb_req.pwdata[7:0];
  assign wr_data = bus_done & apb_req.pwrite & addr_hit &
                   (idx == `SBP_IDX_DATA_PORT);
  assign rd_data = bus_done & ~apb_req.pwrite & addr_hit &
                   (idx == `SBP_IDX_DATA_PORT);

  // ****************************************************
  // Shift data helpers
  // ****************************************************
  logic out_bit;
  logic [7:0] shifted;
  logic byte_end;

  assign out_bit = lsb_first ? q.sh[0] : q.sh[7];
  assign shifted = lsb_first ? {q.sy.mosi2, q.sh[7:1]} :
                               {q.sh[6:0], q.sy.mosi2};
  assign byte_end = (q.xfer == sbp_pkg::SBP_SHIFT) & selected &
                    sample_edge & (q.bitcnt == `SBP_LAST_BIT);

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    d = q;

    // Two flops before any logic reads sck, ss_n or mosi; sleep_deep and miso_dir_out are read directly
    d.sy.sck1 = sck;
    d.sy.sck2 = q.sy.sck1;
    d.sy.sck3 = q.sy.sck2;
    d.sy.sel1 = ss_n;
    d.sy.sel2 = q.sy.sel1;
    d.sy.sel3 = q.sy.sel2;
    d.sy.mosi1 = mosi;
    d.sy.mosi2 = q.sy.mosi1;

    d.ev1 = 1'b0;
    d.ev2 = 1'b0;
    d.txc1 = 1'b0;

    // ---------------- APB slave, one wait state
    if (bus_acc & ~q.pready) begin
      d.pready = 1'b1;
      d.pslverr = ~addr_hit;
      d.rdata = 8'h00;
      if (addr_hit) begin
        case (idx)
          `SBP_IDX_MAIN_CONTROL: d.rdata = q.main_ctl;
          `SBP_IDX_BUFFER_AND_PHASE: d.rdata = q.buf_ctl;
          `SBP_IDX_IRQ_ENABLES: d.rdata = q.ien;
          `SBP_IDX_IRQ_FLAGS: d.rdata = q.flags;
          `SBP_IDX_DATA_PORT: d.rdata = q.rxf[0];
          default: d.rdata = 8'h00;
        endcase
      end
    end else begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
    end

    // ---------------- Register writes; clears come before sets
    if (bus_done & apb_req.pwrite & addr_hit) begin
      case (idx)
        `SBP_IDX_MAIN_CONTROL: d.main_ctl = wbyte & `SBP_MASK_MAIN;
        `SBP_IDX_BUFFER_AND_PHASE: d.buf_ctl = wbyte & `SBP_MASK_BUF;
        `SBP_IDX_IRQ_ENABLES: d.ien = wbyte & `SBP_MASK_IEN;
        `SBP_IDX_IRQ_FLAGS: d.flags = q.flags & ~(wbyte & `SBP_MASK_W1C);
        default: d.flags = d.flags;
      endcase
    end

    if (wr_data) begin
      if (buf_mode) begin
        // Full buffer refuses the byte; software should watch empty flag
        if (!q.tx_full) begin
          d.txbuf = wbyte;
          d.tx_full = 1'b1;
          d.flags[`SBP_BIT_TX_BUFFER_EMPTY_FLAG] = 1'b0;
        end
      end else if (selected && q.bitcnt != 3'h0) begin
        d.flags[`SBP_BIT_TX_COMPLETE_FLAG] = 1'b1;
      end else begin
        d.sh = wbyte;
      end
    end

    // ---------------- Receive queue pop
    if (rd_data && q.rx_cnt != 2'h0) begin
      d.rxf[0] = q.rxf[1];
      d.rx_cnt = q.rx_cnt - 2'h1;
      if (buf_mode && q.rx_cnt == 2'h1) begin
        d.flags[`SBP_BIT_RX_COMPLETE_FLAG] = 1'b0;
      end
    end

    // ---------------- Wait-receive preload while deselected
    if (buf_mode && wait_rx && q.sy.sel2 && q.tx_full && !q.sh_full) begin
      d.sh = q.txbuf;
      d.tx_full = 1'b0;
      d.sh_full = 1'b1;
      d.flags[`SBP_BIT_TX_BUFFER_EMPTY_FLAG] = 1'b1;
    end

    // ---------------- Transfer engine
    if (!selected) begin
      // Partial byte is never pushed, so it is simply lost
      d.xfer = sbp_pkg::SBP_IDLE;
      d.bitcnt = 3'h0;
    end else if (q.xfer == sbp_pkg::SBP_IDLE) begin
      if (select_fell) begin
        d.xfer = sbp_pkg::SBP_SHIFT;
        d.bitcnt = 3'h0;
        d.miso = out_bit;
        if (buf_mode) begin
          d.flags[`SBP_BIT_SELECT_TRIGGER_FLAG] = 1'b1;
        end
      end
    end else begin
      if (setup_edge) begin
        d.miso = out_bit;
      end
      if (sample_edge) begin
        d.bitcnt = q.bitcnt + 3'h1;
        d.sh = shifted;
      end
    end

    // ---------------- Byte end
    if (byte_end) begin
      if (buf_mode) begin
        if (q.rx_cnt == `SBP_RX_DEPTH) begin
          d.flags[`SBP_BIT_BUF_OVERFLOW_FLAG] = 1'b1;
        end else begin
          d.rxf[d.rx_cnt[0]] = shifted;
          d.rx_cnt = d.rx_cnt + 2'h1;
        end
        if (q.tx_full) begin
          // Old shifter content goes out as a dummy until this copy
          d.sh = q.txbuf;
          d.tx_full = 1'b0;
          d.sh_full = 1'b1;
          d.flags[`SBP_BIT_TX_BUFFER_EMPTY_FLAG] = 1'b1;
        end else begin
          d.sh_full = 1'b0;
        end
        d.ev1 = 1'b1;
        d.txc1 = ~q.tx_full;
      end else begin
        d.rxf[0] = shifted;
        d.rx_cnt = 2'h1;
        d.flags[`SBP_BIT_RX_COMPLETE_FLAG] = 1'b1;
      end
    end

    // ---------------- Flag pipeline in buffer mode
    if (q.ev1) begin
      d.flags[`SBP_BIT_RX_COMPLETE_FLAG] = 1'b1;
      d.ev2 = q.txc1;
    end
    if (q.ev2) begin
      d.flags[`SBP_BIT_TX_COMPLETE_FLAG] = 1'b1;
    end

    // ---------------- Pin drive and interrupt
    d.miso_oe = selected & miso_dir_out;
    if (buf_mode) begin
      d.irq = |(q.flags[7:4] & q.ien[7:4]);
    end else begin
      d.irq = q.flags[`SBP_BIT_RX_COMPLETE_FLAG] &
              q.ien[`SBP_BIT_PLAIN_IRQ_ENABLE];
    end
  end

  // ****************************************************
  // Registers
  // ****************************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
      q.sy.sel1 <= 1'b1;
      q.sy.sel2 <= 1'b1;
      q.sy.sel3 <= 1'b1;
      q.main_ctl <= `SBP_RST_REG;
      q.buf_ctl <= `SBP_RST_REG;
      q.ien <= `SBP_RST_REG;
      q.flags <= `SBP_RST_REG;
      q.xfer <= sbp_pkg::SBP_IDLE;
    end else begin
      q <= d;
    end
  end

endmodule

`default_nettype wire

// [sbp_spi_slave_sva.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************
// Port checker
// ****************
module sbp_spi_slave_sva (
  input wire logic clock,
  input wire logic rst_n,
  input wire sbp_pkg::sbp_apb_req_t apb_req,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ss_n,
  input wire logic miso_dir_out,
  input wire logic sleep_deep,
  input wire logic miso_oe,
  input wire logic irq
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  chk_ready_wait:
    assert property (apb_req.psel && apb_req.penable && !pready |=> pready)
    else $error("pready late");
  chk_ready_pulse:
    assert property (pready |=> !pready) else $error("pready held");
  chk_err_unmapped:
    assert property (pready && apb_req.paddr > 8'h10 |->
      pslverr && prdata == 32'h0000_0000) else $error("unmapped accepted");
  chk_err_mapped:
    assert property (pready && apb_req.paddr <= 8'h10 &&
      apb_req.paddr[1:0] == 2'h0 |-> !pslverr) else $error("false error");
  chk_read_upper:
    assert property (pready && !apb_req.pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read upper bits set");
  chk_oe_release:
    assert property ($rose(ss_n) |-> ##[1:5] !miso_oe)
    else $error("miso driven while deselected");
  chk_oe_drive:
    assert property ($fell(ss_n) && miso_dir_out |-> ##[2:6] miso_oe)
    else $error("miso not driven when selected");
  chk_oe_input:
    assert property (!miso_dir_out |=> !miso_oe)
    else $error("miso driven while pin is an input");
  chk_sleep_abort:
    assert property (sleep_deep |=> !miso_oe)
    else $error("miso driven in deep sleep");
  chk_irq_clear:
    assert property ($fell(irq) |-> $past(pready) || $past(pready, 2))
    else $error("irq dropped without software");
  cover property (pslverr);
  cover property ($rose(irq));
  cover property ($rose(miso_oe));
  cover property (sleep_deep && !ss_n);
endmodule

bind sbp_spi_slave sbp_spi_slave_sva u_sva (.clock(clock), .rst_n(rst_n),
  .apb_req(apb_req), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .ss_n(ss_n), .miso_dir_out(miso_dir_out), .sleep_deep(sleep_deep),
  .miso_oe(miso_oe), .irq(irq));
`default_nettype wire

// [sbp_master_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bus master model
// ****************
module sbp_master_model (
  input wire logic clock,
  input wire logic [1:0] mode,
  input wire logic miso,
  input wire logic miso_oe,
  output logic sck,
  output logic mosi,
  output logic ss_n,
  output logic [7:0] rx_byte,
  output logic rx_done
);
  logic last_miso = 1'b0;
  // Released line shows the inverse of its last bit, so stale data fails
  wire line = miso_oe ? miso : ~last_miso;
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    ss_n = 1'b1;
    rx_byte = 8'h00;
    rx_done = 1'b0;
  end
  always @(posedge clock) if (miso_oe) last_miso <= miso;
  // Setup phase 5 clocks, sample phase 3: period stays 8 clocks
  task automatic xfer(input logic [7:0] tx, input int nb);
    logic [7:0] r;
    r = 8'h00;
    sck <= mode[1];
    repeat (3) @(posedge clock);
    ss_n <= 1'b0;
    for (int i = 0; i < nb; i++) begin
      repeat (3) @(posedge clock);
      if (mode[0] || i > 0) sck <= mode[0] ^ mode[1];
      mosi <= tx[7 - i];
      repeat (5) @(posedge clock);
      r = {r[6:0], line};
      sck <= ~(mode[0] ^ mode[1]);
    end
    repeat (3) @(posedge clock);
    sck <= mode[1];
    mosi <= ~mosi;
    repeat (3) @(posedge clock);
    ss_n <= 1'b1;
    rx_byte <= r;
    rx_done <= (nb == 8);
    @(posedge clock);
    rx_done <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [test_spi_slave_buffered_port.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************
// Bench
// ****************
module test_spi_slave_buffered_port;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  sbp_pkg::sbp_apb_req_t req = '0;
  logic [31:0] prdata;
  logic pready, pslverr, sck, mosi, ss_n, miso_o, miso_oe, irq, rx_done;
  logic [7:0] rx_byte, a, b, c;
  logic [1:0] mode = 2'h0;
  logic sleep_deep = 1'b0;
  logic miso_dir_out = 1'b1;
  logic [8:0] exp_rd[$];
  logic [8:0] exp_spi[$];
  int n_errors = 0;
  int samples_checked = 0;

  initial begin
    forever #12.5 clock = ~clock;
  end

  sbp_spi_slave u_dut (.clock(clock), .rst_n(rst_n), .apb_req(req),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sck(sck),
    .mosi(mosi), .ss_n(ss_n), .miso_dir_out(miso_dir_out),
    .sleep_deep(sleep_deep), .miso_o(miso_o), .miso_oe(miso_oe), .irq(irq));
  sbp_master_model u_mst (.clock(clock), .mode(mode), .miso(miso_o),
    .miso_oe(miso_oe), .sck(sck), .mosi(mosi), .ss_n(ss_n),
    .rx_byte(rx_byte), .rx_done(rx_done));

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Idle edge first, so a release never meets a new setup in one step
  task automatic apb(input logic wr, input logic [7:0] ad,
                     input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock);
    req <= '{1'b1, 1'b0, wr, ad, {24'h00_0000, d}};
    @(posedge clock);
    req.penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (!pready && n < 16);
    if (!pready) begin
      n_errors++;
      stop_test();
    end else begin
      req.psel <= 1'b0;
      req.penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    apb(1'b1, ad, d);
  endtask

  task automatic rd(input logic [7:0] ad, input logic [8:0] e);
    exp_rd.push_back(e);
    apb(1'b0, ad, 8'h00);
  endtask

  task automatic spi(input logic [7:0] mtx, input logic [7:0] e, input int nb);
    if (nb == 8) exp_spi.push_back({1'b0, e});
    u_mst.xfer(mtx, nb);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge clock);
    check({8'h00, irq}, {8'h00, e});
  endtask

  always @(posedge clock) begin
    if (pready && !req.pwrite) begin
      check({pslverr, prdata[7:0]}, exp_rd.pop_front());
    end
    if (rx_done) check({1'b0, rx_byte}, exp_spi.pop_front());
  end

  initial begin
    repeat (100000) @(posedge clock);
    n_errors++;
    stop_test();
  end

  initial begin
    void'($urandom(61));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++) rd(8'(4 * i), {i == 5, 8'h00});
    wr(8'h04, 8'hFF);
    rd(8'h04, 9'h0C7);
    wr(8'h08, 8'hFF);
    rd(8'h08, 9'h0F1);
    wr(8'h00, 8'h7F);
    rd(8'h00, 9'h077);
    wr(8'h00, 8'h01);
    wr(8'h08, 8'h01);
    $display("test registers done");
    for (int m = 0; m < 4; m++) begin
      mode <= 2'(m);
      wr(8'h04, 8'(m));
      a = 8'($urandom);
      b = 8'($urandom);
      wr(8'h10, a);
      spi(b, a, 8);
      rd(8'h0C, 9'h080);
      irq_is(1'b1);
      wr(8'h0C, 8'h80);
      rd(8'h10, {1'b0, b});
      irq_is(1'b0);
    end
    wr(8'h10, a);
    fork
      spi(b, a, 8);
      begin
        repeat (30) @(posedge clock);
        wr(8'h10, 8'h5A);
      end
    join
    rd(8'h0C, 9'h0C0);
    wr(8'h0C, 8'hC0);
    c = 8'($urandom);
    miso_dir_out <= 1'b0;
    fork
      spi(c, 8'h00, 7);
      begin
        repeat (30) @(posedge clock);
        check({8'h00, miso_oe}, 9'h000);
      end
    join
    miso_dir_out <= 1'b1;
    fork
      spi(c, 8'h00, 7);
      begin
        repeat (20) @(posedge clock);
        check({8'h00, miso_oe}, 9'h001);
        sleep_deep <= 1'b1;
        repeat (10) @(posedge clock);
        wr(8'h10, a);
      end
    join
    sleep_deep <= 1'b0;
    rd(8'h0C, 9'h000);
    spi(c, 8'h00, 4);
    wr(8'h10, a);
    spi(b, a, 8);
    rd(8'h0C, 9'h080);
    wr(8'h0C, 8'h80);
    rd(8'h10, {1'b0, b});
    $display("test normal done");
    mode <= 2'h0;
    wr(8'h04, 8'h80);
    wr(8'h0C, 8'hFF);
    wr(8'h10, 8'h43);
    spi(a, b, 8);
    wr(8'h10, 8'h44);
    wr(8'h10, 8'h45);
    spi(c, 8'h43, 8);
    rd(8'h0C, 9'h0B0);
    spi(b, 8'h44, 8);
    rd(8'h0C, 9'h0F1);
    rd(8'h10, {1'b0, a});
    rd(8'h10, {1'b0, c});
    rd(8'h0C, 9'h071);
    $display("test buffer done");
    wr(8'h0C, 8'hFF);
    wr(8'h04, 8'hC0);
    wr(8'h10, 8'h46);
    wr(8'h10, 8'h47);
    spi(a, 8'h46, 8);
    spi(b, 8'h47, 8);
    wr(8'h08, 8'h80);
    irq_is(1'b1);
    rd(8'h10, {1'b0, a});
    rd(8'h10, {1'b0, b});
    irq_is(1'b0);
    $display("test wait receive done");
    stop_test();
  end
endmodule
`default_nettype wire
